/* File: src/sio_device.sv */
// Converter-side serial interface with options register and integrity monitor
`default_nettype none
module sio_device
   import sio_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   sio_if.dev               link,
   input  wire logic        result_valid,
   input  wire logic [23:0] result_data,
   input  wire logic [1:0]  result_chan,
   output logic             continuous_read_enable,
   output logic             output_reset_enable,
   output logic             append_status,
   output logic             integrity_enable,
   output logic [1:0]       protection,
   output logic             integrity_error
);
   // ----------------------------------------------------------------
   // Conversion result hand-over (mclk side)
   // ----------------------------------------------------------------
   logic [23:0] hold_data;
   logic [1:0]  hold_chan;
   logic        res_tgl;
   logic [6:0]  cfg_s1, cfg_s2;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hold_data <= 24'h00_0000;
         hold_chan <= 2'h0;
         res_tgl   <= 1'b0;
      end
      else if (result_valid)
      begin
         hold_data <= result_data;
         hold_chan <= result_chan;
         res_tgl   <= ~res_tgl;
      end
   end

   // ----------------------------------------------------------------
   // Link clock domain state
   // ----------------------------------------------------------------
   logic [15:0] options;
   logic [15:0] user_regs [USER_COUNT];
   logic        reg_err, crc_err, ready_n, res_t1, res_t2, res_seen;
   logic        miso_q, oe_q, rd_q, frame_rst_n;
   logic [23:0] data_reg;
   logic [1:0]  data_chan;
   logic [5:0]  bitcnt, addr_q;
   logic [39:0] sr, tx;
   logic [7:0]  cmd_q;
   // Frame state ends with the select line
   assign frame_rst_n = rst_n & ~link.cs_n;

   // Settings toward the user side
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_s1 <= 7'h00;
         cfg_s2 <= 7'h00;
      end
      else
      begin
         cfg_s1 <= {reg_err, options[BIT_OUTPUT_RESET], options[BIT_CONT_READ],
                    options[BIT_APPEND_STAT], options[BIT_INTEGRITY], options[PROT_LSB +: 2]};
         cfg_s2 <= cfg_s1;
      end
   end
   assign integrity_error        = cfg_s2[6];
   assign output_reset_enable    = cfg_s2[5];
   assign continuous_read_enable = cfg_s2[4];
   assign append_status          = cfg_s2[3];
   assign integrity_enable       = cfg_s2[2];
   assign protection             = cfg_s2[1:0];

   // ----------------------------------------------------------------
   // Command decode and read data
   // ----------------------------------------------------------------
   logic        cont, rd, at_cmd, wend, wok, commit, data_busy;
   logic [1:0]  prot;
   logic [39:0] next_sr, txload;
   logic [7:0]  cmd, rchk, status;
   logic [5:0]  addr, rlen;
   logic [31:0] rv, lead;
   logic [23:0] xsum;
   logic [15:0] wdata;

   always_comb
   begin
      cont    = options[BIT_CONT_READ];
      prot    = options[PROT_LSB +: 2];
      next_sr = {sr[38:0], link.mosi};
      cmd     = next_sr[7:0];
      at_cmd  = bitcnt == BIT_CMD_LAST;
      rd      = cont | cmd[CMD_READ_BIT];
      addr    = cont ? ADDR_DATA : cmd[5:0];
      rlen    = sio_reg_len(addr, options[BIT_APPEND_STAT]);
      status  = {ready_n, crc_err, reg_err, 3'b000, data_chan};
      xsum    = 24'h00_0000;
      for (int i = 0; i < USER_COUNT; i++)
         xsum = xsum ^ {8'h00, user_regs[i]};
      case (addr)
         ADDR_STATUS   : rv = {24'h00_0000, status};
         ADDR_OPTIONS  : rv = {16'h0000, options & OPT_WRITE_MASK};
         ADDR_INTEGRITY_CHECKSUM_REGISTER : rv = options[BIT_INTEGRITY] ? {8'h00, xsum} : 32'h0000_0000;
         ADDR_DATA     : rv = options[BIT_APPEND_STAT] ? {data_reg, status}
                                                       : {8'h00, data_reg};
         default       : rv = (addr[5:2] == ADDR_USER_PAGE) ? {16'h0000, user_regs[addr[1:0]]}
                                                            : 32'h0000_0000;
      endcase
      lead    = rv << (6'd32 - rlen);
      rchk    = sio_check({cmd, lead, 8'h00}, 6'(rlen + 6'd8), prot, 1'b1);
      txload  = (prot == PROT_NONE) ? {lead, 8'h00}
                                    : ({lead, 8'h00} | ({32'h0000_0000, rchk} << (6'd32 - rlen)));
      wend    = bitcnt == ((prot == PROT_NONE) ? BIT_WR_LAST : BIT_WR_LAST_CHK);
      wdata   = (prot == PROT_NONE) ? next_sr[15:0] : next_sr[23:8];
      // code 11 acts as code 10
      wok     = (prot == PROT_NONE) ||
                (sio_check({cmd_q, wdata, 24'h00_0000}, 6'd24, prot, 1'b0) == next_sr[7:0]);
      commit  = ~rd_q & (bitcnt > BIT_CMD_LAST) & wend;
      data_busy = oe_q & (addr_q == ADDR_DATA);
   end

   // ----------------------------------------------------------------
   // Frame shifter
   // ----------------------------------------------------------------
   always_ff @(posedge link.sclk or negedge frame_rst_n)
   begin
      if (!frame_rst_n)
      begin
         bitcnt <= 6'h00;
         sr     <= 40'h00_0000_0000;
         tx     <= 40'h00_0000_0000;
         miso_q <= 1'b0;
         oe_q   <= 1'b0;
         rd_q   <= 1'b0;
         cmd_q  <= 8'h00;
         addr_q <= 6'h00;
      end
      else
      begin
         sr <= next_sr;
         if (bitcnt != 6'h3F)
            bitcnt <= bitcnt + 6'h01;
         if (at_cmd)
         begin
            cmd_q  <= cmd;
            addr_q <= addr;
            rd_q   <= rd;
            oe_q   <= rd;
            miso_q <= txload[39];
            tx     <= txload << 1;
         end
         else
         begin
            miso_q <= tx[39];
            tx     <= tx << 1;
         end
      end
   end
   assign link.miso    = miso_q;
   assign link.miso_oe = oe_q;
   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge link.sclk or negedge rst_n)
   begin
      if (!rst_n)
         options <= OPT_RESET;
      else if (commit && wok && addr_q == ADDR_OPTIONS)
         options <= wdata & OPT_WRITE_MASK;
      else if (at_cmd && cont && cmd == CMD_EXIT)
         options[BIT_CONT_READ] <= 1'b0;
   end

   always_ff @(posedge link.sclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < USER_COUNT; i++)
            user_regs[i] <= 16'h0000;
      end
      else if (commit && wok && addr_q[5:2] == ADDR_USER_PAGE)
         user_regs[addr_q[1:0]] <= wdata;
   end

   // Integrity and protection error flags
   always_ff @(posedge link.sclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reg_err <= 1'b0;
         crc_err <= 1'b0;
      end
      else
      begin
         if (commit && wok && addr_q[5:2] == ADDR_USER_PAGE && options[BIT_INTEGRITY] &&
             wdata != user_regs[addr_q[1:0]])
            reg_err <= 1'b1;
         else if (commit && wok && addr_q == ADDR_OPTIONS && !wdata[BIT_INTEGRITY])
            reg_err <= 1'b0;
         if (commit && !wok)
            crc_err <= 1'b1;
         else if (at_cmd && rd && addr == ADDR_STATUS)
            crc_err <= 1'b0;
      end
   end

   // New results cross by toggle, data and channel copied together
   always_ff @(posedge link.sclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         res_t1    <= 1'b0;
         res_t2    <= 1'b0;
         res_seen  <= 1'b0;
         data_reg  <= 24'h00_0000;
         data_chan <= 2'h0;
         ready_n   <= 1'b1;
      end
      else
      begin
         res_t1 <= res_tgl;
         res_t2 <= res_t1;
         if (res_t2 != res_seen && !data_busy && !(at_cmd && rd && addr == ADDR_DATA))
         begin
            res_seen  <= res_t2;
            data_reg  <= hold_data;
            data_chan <= hold_chan;
            ready_n   <= 1'b0;
         end
         else if (at_cmd && rd && addr == ADDR_DATA)
            ready_n <= 1'b1;
      end
   end
endmodule
`default_nettype wire

/* File: src/sio_pkg.sv */
// Shared constants, types and check-byte helpers for the serial options link
`default_nettype none
package sio_pkg;
   // Register addresses
   localparam logic [5:0]  ADDR_STATUS      = 6'h00;
   localparam logic [5:0]  ADDR_OPTIONS     = 6'h02;
   localparam logic [5:0]  ADDR_INTEGRITY_CHECKSUM_REGISTER    = 6'h03;
   localparam logic [5:0]  ADDR_DATA        = 6'h04;
   localparam logic [3:0]  ADDR_USER_PAGE   = 4'h4;
   localparam int          USER_COUNT       = 4;
   // Options register layout
   localparam logic [15:0] OPT_RESET        = 16'h0000;
   localparam logic [15:0] OPT_WRITE_MASK   = 16'h19ED;
   localparam int          BIT_OUTPUT_RESET = 8;
   localparam int          BIT_CONT_READ    = 7;
   localparam int          BIT_APPEND_STAT  = 6;
   localparam int          BIT_INTEGRITY    = 5;
   localparam int          PROT_LSB         = 2;
   localparam logic [1:0]  PROT_NONE        = 2'b00;
   localparam logic [1:0]  PROT_XOR_READ    = 2'b01;
   // Status byte layout
   localparam int          ST_READY_N       = 7;
   localparam int          ST_CRC_ERR       = 6;
   localparam int          ST_REG_ERR       = 5;
   // Command byte
   localparam int          CMD_READ_BIT     = 6;
   localparam logic [7:0]  CMD_EXIT         = 8'h44;
   localparam logic [7:0]  CRC_POLY         = 8'h07;
   // Frame bit positions of the last command bit and of a write's last bit
   localparam logic [5:0]  BIT_CMD_LAST     = 6'h07;
   localparam logic [5:0]  BIT_WR_LAST      = 6'h17;
   localparam logic [5:0]  BIT_WR_LAST_CHK  = 6'h1F;
   // Host clock divider: mclk cycles per link bit
   localparam logic [2:0]  PH_SAMPLE        = 3'h3;
   localparam logic [2:0]  PH_RISE          = 3'h4;
   localparam logic [2:0]  PH_LAST          = 3'h7;

   typedef enum logic [1:0] {
      SIO_IDLE   = 2'b00,
      SIO_SHIFT  = 2'b01,
      SIO_FINISH = 2'b11
   } sio_state_e;

   // Payload length in bits of a register
   function automatic logic [5:0] sio_reg_len(input logic [5:0] addr, input logic append);
      logic [5:0] n;
      n = 6'd8;
      if (addr == ADDR_OPTIONS || addr[5:2] == ADDR_USER_PAGE)
         n = 6'd16;
      else if (addr == ADDR_INTEGRITY_CHECKSUM_REGISTER)
         n = 6'd24;
      else if (addr == ADDR_DATA)
         n = append ? 6'd32 : 6'd24;
      return n;
   endfunction

   // XOR checksum or CRC-8 over the top nbits of msg
   function automatic logic [7:0] sio_check(input logic [47:0] msg, input logic [5:0] nbits,
                                            input logic [1:0] prot, input logic is_read);
      logic [7:0] c;
      logic       fb;
      c = 8'h00;
      for (int i = 0; i < 48; i++)
      begin
         if (i < int'(nbits))
         begin
            if (is_read && prot == PROT_XOR_READ)
            begin
               if (i % 8 == 0)
                  c = c ^ msg[47 - i -: 8];
            end
            else
            begin
               fb = c[7] ^ msg[47 - i];
               c  = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
            end
         end
      end
      return c;
   endfunction
endpackage
`default_nettype wire

/* File: src/sio_if.sv */
// Serial link between the host controller and the converter interface
`default_nettype none
interface sio_if;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic miso;
   logic miso_oe;
   logic miso_line;

   // Pulled high when the device does not drive
   assign miso_line = miso_oe ? miso : 1'b1;

   modport dev  (input sclk, input cs_n, input mosi, output miso, output miso_oe);
   modport host (output sclk, output cs_n, output mosi, input miso_line);
endinterface
`default_nettype wire

/* File: src/sio_host.sv */
// Host-side serial master: generates the link clock and frames register transfers
`default_nettype none
module sio_host
   import sio_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   sio_if.host              link,
   input  wire logic        req_valid,
   input  wire logic        req_write,
   input  wire logic [5:0]  req_addr,
   input  wire logic [15:0] req_wdata,
   output logic             req_ready,
   output logic             rsp_valid,
   output logic [31:0]      rsp_data,
   output logic             rsp_check_ok
);
   sio_state_e  state;
   logic [2:0]  ph;
   logic [5:0]  bitn;
   logic [5:0]  total;
   logic [5:0]  len;
   logic        is_rd;
   logic [7:0]  cmd_q;
   logic [47:0] txs;
   logic [47:0] rxs;
   logic        sclk_q;
   logic        cs_q;
   logic        mosi_q;
   logic        miso_s1;
   logic        miso_s2;
   logic        opt_cont;
   logic        opt_append;
   logic [1:0]  opt_prot;

   // ----------------------------------------------------------------
   // Request framing
   // ----------------------------------------------------------------
   logic [7:0]  ncmd;
   logic        nrd;
   logic [5:0]  nlen;
   logic [7:0]  wchk;
   logic [47:0] rx_body;
   logic [31:0] rdat;
   logic [7:0]  rchk;

   always_comb
   begin
      ncmd    = {1'b0, ~req_write, req_addr};
      nrd     = opt_cont | ~req_write;
      nlen    = sio_reg_len(opt_cont ? ADDR_DATA : req_addr, opt_append);
      wchk    = sio_check({ncmd, req_wdata, 24'h00_0000}, 6'd24, opt_prot, 1'b0);
      rx_body = (opt_prot == PROT_NONE) ? rxs : (rxs >> 8);
      rdat    = 32'(rx_body & ((48'h1 << len) - 48'h1));
      rchk    = sio_check({cmd_q, 32'(rdat << (6'd32 - len)), 8'h00},
                          6'(len + 6'd8), opt_prot, 1'b1);
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state  <= SIO_IDLE;
         ph     <= 3'h0;
         bitn   <= 6'h00;
         total  <= 6'h00;
         len    <= 6'h00;
         is_rd  <= 1'b0;
         cmd_q  <= 8'h00;
         txs    <= 48'h0000_0000_0000;
         rxs    <= 48'h0000_0000_0000;
         sclk_q <= 1'b1;
         cs_q   <= 1'b1;
         mosi_q <= 1'b0;
      end
      else
      begin
         case (state)
            SIO_IDLE :
            begin
               if (req_valid)
               begin
                  state <= SIO_SHIFT;
                  ph    <= 3'h0;
                  bitn  <= 6'h00;
                  cs_q  <= 1'b0;
                  cmd_q <= ncmd;
                  is_rd <= nrd;
                  len   <= nrd ? nlen : 6'd16;
                  total <= 6'((nrd ? nlen : 6'd16) + 6'd8 +
                              ((opt_prot == PROT_NONE) ? 6'd0 : 6'd8));
                  txs   <= nrd ? {ncmd, 40'h00_0000_0000}
                               : {ncmd, req_wdata, wchk, 16'h0000};
               end
            end
            SIO_SHIFT :
            begin
               ph <= ph + 3'h1;
               if (ph == 3'h0)
               begin
                  sclk_q <= 1'b0;
                  mosi_q <= txs[47];
                  txs    <= txs << 1;
               end
               if (ph == PH_SAMPLE)
                  rxs <= {rxs[46:0], miso_s2};
               if (ph == PH_RISE)
                  sclk_q <= 1'b1;
               if (ph == PH_LAST)
               begin
                  if (bitn == total - 6'h01)
                     state <= SIO_FINISH;
                  else
                     bitn <= bitn + 6'h01;
               end
            end
            SIO_FINISH :
            begin
               cs_q  <= 1'b1;
               state <= SIO_IDLE;
            end
            default :
               state <= SIO_IDLE;
         endcase
      end
   end

   // Answer to the user
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rsp_valid    <= 1'b0;
         rsp_data     <= 32'h0000_0000;
         rsp_check_ok <= 1'b0;
         req_ready    <= 1'b0;
      end
      else
      begin
         req_ready <= (state == SIO_IDLE) && !req_valid;
         rsp_valid <= state == SIO_FINISH;
         if (state == SIO_FINISH)
         begin
            rsp_data     <= is_rd ? rdat : 32'h0000_0000;
            rsp_check_ok <= !is_rd || opt_prot == PROT_NONE || rchk == rxs[7:0];
         end
      end
   end

   // Tracks the device options from own writes
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         opt_cont   <= 1'b0;
         opt_append <= 1'b0;
         opt_prot   <= PROT_NONE;
      end
      else if (state == SIO_IDLE && req_valid)
      begin
         if (!opt_cont && req_write && req_addr == ADDR_OPTIONS)
         begin
            opt_cont   <= req_wdata[BIT_CONT_READ];
            opt_append <= req_wdata[BIT_APPEND_STAT];
            opt_prot   <= req_wdata[PROT_LSB +: 2];
         end
         else if (opt_cont && ncmd == CMD_EXIT)
            opt_cont <= 1'b0;
      end
   end

   // Data line from the device is synchronised
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         miso_s1 <= 1'b1;
         miso_s2 <= 1'b1;
      end
      else
      begin
         miso_s1 <= link.miso_line;
         miso_s2 <= miso_s1;
      end
   end

   assign link.sclk = sclk_q;
   assign link.cs_n = cs_q;
   assign link.mosi = mosi_q;
endmodule
`default_nettype wire

/* File: test/sio_link_properties.sv */
// Link-level properties of the serial options interface
`default_nettype none
module sio_link_properties
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe,
   input wire logic miso_line
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] edges;
   logic       sclk_q;
   // ----
   // Rising link edges in a frame
   // ----
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         sclk_q <= 1'b1;
      else
         sclk_q <= sclk;
   end
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         edges <= 6'h00;
      else if (cs_n)
         edges <= 6'h00;
      else if (sclk && !sclk_q)
         edges <= edges + 6'h01;
   end
   // ----
   // Properties
   // ----
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence low_phase;
      !sclk [*4] ##1 sclk;
   endsequence
   frame_bytes_a: assert property ($rose(cs_n) |-> edges[2:0] == 3'h0 && edges >= 6'h10)
      else $error("frame not whole bytes");
   bit_timing_a: assert property ($fell(sclk) |-> low_phase)
      else $error("link clock low phase wrong");
   idle_clock_a: assert property (cs_n |-> sclk)
      else $error("link clock not idle high");
   early_drive_a: assert property (!cs_n && edges < 6'h07 |-> !miso_oe)
      else $error("device drives during command");
   released_line_a: assert property (cs_n && $past(cs_n) |-> !miso_oe && !miso && miso_line)
      else $error("data line not released");
   data_held_a: assert property (miso_oe && !cs_n |=> miso_oe || cs_n)
      else $error("device dropped data line");
   mosi_stable_a: assert property (sclk && $past(sclk) && !cs_n |-> $stable(mosi))
      else $error("host data moved while clock high");
   miso_stable_a: assert property (!sclk && !$past(sclk) |-> $stable(miso_line))
      else $error("device data moved while clock low");
endmodule
`default_nettype wire

/* File: test/serial_interface_options_control_tb.sv */
// Testbench joining host and device over the serial options link
`default_nettype none
module serial_interface_options_control_tb
   import sio_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk, rst_n, req_valid, req_write, req_ready, rsp_valid, rsp_check_ok;
   logic        res_v, cre, ore, aps, ien, ierr;
   logic [1:0]  res_c, prot;
   logic [5:0]  req_addr;
   logic [15:0] req_wdata, v;
   logic [23:0] res_d;
   logic [31:0] rsp_data;
   logic [7:0]  tail;
   int          fails, cmp_count, cycles, nbits;
   sio_if link ();
   sio_host sio_host_i (.mclk(mclk), .rst_n(rst_n), .link(link), .req_valid(req_valid),
      .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .rsp_check_ok(rsp_check_ok));
   sio_device sio_device_i (.mclk(mclk), .rst_n(rst_n), .link(link), .result_valid(res_v),
      .result_data(res_d), .result_chan(res_c), .continuous_read_enable(cre),
      .output_reset_enable(ore), .append_status(aps), .integrity_enable(ien),
      .protection(prot), .integrity_error(ierr));
   sio_link_properties sio_link_properties_i (.mclk(mclk), .rst_n(rst_n), .sclk(link.sclk),
      .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe),
      .miso_line(link.miso_line));
   // ----
   // Clock, timeout and link monitor
   // ----
   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         fails++;
         wrap_up();
      end
   end
   always @(negedge link.cs_n) nbits = 0;
   always @(posedge link.sclk) if (!link.cs_n) nbits++;
   always @(negedge link.sclk) if (!link.cs_n) tail = {tail[6:0], link.miso_line};
   // ----
   // Tasks
   // ----
   function automatic logic [7:0] crc8(input logic [23:0] m);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 23; i >= 0; i--)
         c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? CRC_POLY : 8'h00);
      return c;
   endfunction
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic xfer(input logic wr, input logic [5:0] a, input logic [15:0] d);
      while (req_ready !== 1'b1)
      begin
         @(posedge mclk);
         #1;
      end
      req_write = wr;
      req_addr = a;
      req_wdata = d;
      req_valid = 1'b1;
      @(posedge mclk);
      #1;
      req_valid = 1'b0;
      while (rsp_valid !== 1'b1)
      begin
         @(posedge mclk);
         #1;
      end
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] exp, input string what);
      xfer(1'b0, a, 16'h0000);
      check(what, exp, rsp_data);
      check("check ok", 32'h0000_0001, {31'h0, rsp_check_ok});
   endtask
   task automatic outs(input logic [6:0] exp);
      repeat (4) @(posedge mclk);
      #1;
      check("options outputs", {25'h0, exp}, {25'h0, cre, ore, aps, ien, prot, ierr});
   endtask
   task automatic pulse(input logic [23:0] d, input logic [1:0] c);
      res_d = d;
      res_c = c;
      res_v = 1'b1;
      @(posedge mclk);
      #1;
      res_v = 1'b0;
   endtask
   task automatic wrap_up();
      if (fails == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // ----
   // Main sequence
   // ----
   initial
   begin
      logic [23:0] dv [2];
      logic [1:0]  ch [2];
      dv = '{24'hAB_CDEF, 24'h12_3456};
      ch = '{2'h2, 2'h1};
      {rst_n, req_valid, req_write, req_addr, req_wdata, res_v, res_d, res_c} = '0;
      repeat (8) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      outs(7'h00);
      rd(ADDR_OPTIONS, 32'h0000_0000, "options reset");
      xfer(1'b1, ADDR_OPTIONS, 16'h0752);
      rd(ADDR_OPTIONS, 32'h0000_0140, "reserved bits");
      outs(7'h30);
      for (int i = 0; i < 2; i++)
      begin
         pulse(dv[i], ch[i]);
         rd(ADDR_STATUS, {30'h0, ch[i]}, "status");
         rd(ADDR_DATA, {dv[i], 6'h00, ch[i]}, "data with status");
      end
      xfer(1'b1, 6'h10, 16'h1234);
      xfer(1'b1, 6'h11, 16'h00FF);
      rd(ADDR_INTEGRITY_CHECKSUM_REGISTER, 32'h0000_0000, "checksum off");
      xfer(1'b1, ADDR_OPTIONS, 16'h0020);
      rd(ADDR_INTEGRITY_CHECKSUM_REGISTER, 32'h0000_12CB, "checksum on");
      xfer(1'b1, ADDR_OPTIONS, 16'h0020);
      xfer(1'b1, ADDR_DATA, 16'h5A5A);
      outs(7'h08);
      xfer(1'b1, 6'h11, 16'h0F00);
      outs(7'h09);
      rd(ADDR_STATUS, 32'h0000_00A1, "status error");
      xfer(1'b1, ADDR_OPTIONS, 16'h0000);
      outs(7'h00);
      for (int p = 1; p < 4; p++)
      begin
         v = {12'h000, p[1:0], 2'b00};
         xfer(1'b1, ADDR_OPTIONS, v);
         rd(ADDR_OPTIONS, {16'h0000, v}, "protected read");
         check("frame bits", 32'h0000_0020, nbits);
         check("check byte", {24'h0, (p == 1) ? 8'h42 ^ v[15:8] ^ v[7:0] : crc8({8'h42, v})},
            {24'h0, tail});
         xfer(1'b1, 6'h12, 16'hA5A5);
         rd(6'h12, 32'h0000_A5A5, "crc write");
      end
      xfer(1'b1, ADDR_OPTIONS, 16'h0000);
      pulse(24'h0F_0F0F, 2'h3);
      xfer(1'b1, ADDR_OPTIONS, 16'h0080);
      outs(7'h40);
      rd(ADDR_STATUS, 32'h000F_0F0F, "streamed data");
      rd(ADDR_DATA, 32'h000F_0F0F, "continuous data");
      outs(7'h00);
      wrap_up();
   end
endmodule
`default_nettype wire
